// ---- logic/tsc_t1e1_tx_sig_ctrl.sv ----
// Transmit framing, density monitor/enforcer, loop code, signaling insertion and milliwatt.
// Assumes an APB master on pclk and one bit per pclk cycle on each stream when valid.
// Notes on behaviour
// - Framing bit pattern D4 or ESF by format
// - Monitor both streams for zero runs, sparse windows
// - Transmit violation status bit 6, receive bit 7
// - Enforcer set forces density on transmit stream
// - Loop enable replaces data with repeating code
// - T1 enables, channels 1-24, bit 0 lowest
// - Enabled channels take signaling from store only
// - E1 first register: channels 7-1, upper select
// - Upper select sources upper CAS nibble externally
// - E1 second register maps channels 15 to 8
// - E1 third register: channels 22-16, lower select
// - Lower select sources lower CAS nibble externally
// - Fourth register maps channels 30 to 23
// - Global enable off blocks store; enables choose stuffing
// - Milliwatt enable replaces receive channel data
module tsc_t1e1_tx_sig_ctrl
    import tsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    input wire tsc_tx_slot_t tx_in,
    input wire logic [7:0] loop_code_def_low,
    input wire logic [7:0] loop_code_def_high,
    input wire logic [7:0] first_tx_signaling_reg,
    output logic tx_out,
    output logic tx_out_valid,
    input wire tsc_rx_slot_t rx_in,
    output logic rx_out,
    output logic rx_out_valid,
    output logic frame_esf,
    output logic [29:0] b7_stuff_sel
);

    // ****************************************************************
    // Register bus
    // ****************************************************************
    logic [7:0] txctl_ff;
    logic [7:0] comctl_ff;
    logic [7:0] ssie_ff [4];
    logic [7:0] dmw1_ff;
    logic [7:0] line_ff;
    logic [7:0] irqen_ff;
    logic [7:0] sts_ff;
    logic [7:0] rdata_ff;
    logic err_ff;
    logic [5:0] idx;
    logic setup;
    logic wr_en;
    logic wr_hit;
    logic sel_txctl;
    logic sel_comctl;
    logic sel_ssie [4];
    logic sel_dmw1;
    logic sel_info;
    logic sel_line;
    logic sel_irqen;
    logic sel_irqclr;
    logic mapped;
    logic [7:0] rd_byte;
    logic [7:0] wbyte;
    logic [7:0] clr_mask;
    logic [7:0] sts_set;
    logic [7:0] nxt_sts;

    assign idx = paddr[7:2];
    assign setup = psel & ~penable;
    assign pready = psel & penable;
    assign wr_en = pready & pwrite & pstrb[0];
    assign wr_hit = wr_en & mapped;
    assign wbyte = pwdata[7:0];
    assign sel_txctl = idx == IDX_TXCTL;
    assign sel_comctl = idx == IDX_COMCTL;
    assign sel_ssie[0] = idx == IDX_INS_EN1;
    assign sel_ssie[1] = idx == IDX_INS_EN2;
    assign sel_ssie[2] = idx == IDX_INS_EN3;
    assign sel_ssie[3] = idx == IDX_INS_EN4;
    assign sel_dmw1 = idx == IDX_DMW1;
    assign sel_info = idx == IDX_INFO;
    assign sel_line = idx == IDX_LINE;
    assign sel_irqen = idx == IDX_IRQEN;
    assign sel_irqclr = idx == IDX_IRQCLR;
    assign mapped = (paddr[1:0] == 2'h0) & (sel_txctl | sel_comctl | sel_ssie[0] | sel_ssie[1]
        | sel_ssie[2] | sel_ssie[3] | sel_dmw1 | sel_info | sel_line | sel_irqen | sel_irqclr);
    assign rd_byte = ~mapped ? 8'h00 :
        sel_txctl ? txctl_ff :
        sel_comctl ? comctl_ff :
        sel_ssie[0] ? ssie_ff[0] :
        sel_ssie[1] ? ssie_ff[1] :
        sel_ssie[2] ? ssie_ff[2] :
        sel_ssie[3] ? ssie_ff[3] :
        sel_dmw1 ? dmw1_ff :
        sel_info ? sts_ff :
        sel_line ? line_ff :
        sel_irqen ? irqen_ff : 8'h00;
    assign prdata = {24'h000000, rdata_ff};
    assign pslverr = pready & err_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_ff <= REG_RST;
        end else if (setup) begin
            rdata_ff <= rd_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_ff <= 1'b0;
        end else if (setup) begin
            err_ff <= ~mapped;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            txctl_ff <= REG_RST;
        end else if (wr_hit && sel_txctl) begin
            txctl_ff <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            comctl_ff <= REG_RST;
        end else if (wr_hit && sel_comctl) begin
            comctl_ff <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmw1_ff <= REG_RST;
        end else if (wr_hit && sel_dmw1) begin
            dmw1_ff <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_ff <= REG_RST;
        end else if (wr_hit && sel_line) begin
            line_ff <= wbyte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irqen_ff <= REG_RST;
        end else if (wr_hit && sel_irqen) begin
            irqen_ff <= wbyte;
        end
    end

    // One stored byte per shared offset; the line mode only changes its meaning.
    for (genvar r = 0; r < 4; r++) begin : g_ssie
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                ssie_ff[r] <= REG_RST;
            end else if (wr_en && mapped && sel_ssie[r]) begin
                ssie_ff[r] <= wbyte;
            end
        end
    end

    // ****************************************************************
    // Control decode and channel maps
    // ****************************************************************
    tsc_ctrl_t ctrl;
    logic e1;
    logic gse;
    logic [31:0] t1_vec;
    logic [31:0] e1_vec;
    logic [31:0] chan_en_vec;
    logic tx_chan_en;

    assign ctrl.esf = comctl_ff[FMT_ESF_BIT];
    assign ctrl.enforce = comctl_ff[ENFORCE_BIT];
    assign ctrl.loop_code = comctl_ff[LOOP_CODE_BIT];
    assign e1 = line_ff[LINE_E1_BIT];
    assign gse = txctl_ff[GSE_BIT];
    assign frame_esf = ctrl.esf;
    assign t1_vec = {7'h00, ssie_ff[2], ssie_ff[1], ssie_ff[0], 1'b0};
    assign e1_vec = {1'b0, ssie_ff[3], ssie_ff[2][7:1], ssie_ff[1], ssie_ff[0][7:1], 1'b0};
    assign chan_en_vec = e1 ? e1_vec : t1_vec;
    assign tx_chan_en = chan_en_vec[tx_in.chan];
    assign b7_stuff_sel = chan_en_vec[30:1];

    // ****************************************************************
    // Transmit data selection
    // ****************************************************************
    logic [3:0] lc_ptr_ff;
    logic [15:0] lc_word;
    logic lc_bit;
    logic [4:0] d4_pos;
    logic d4_bit;
    logic esf_fps_slot;
    logic esf_bit;
    logic f_bit;
    logic [3:0] upper_nib;
    logic [3:0] lower_nib;
    logic [7:0] cas_word;
    logic cas_bit;
    logic sig_take;
    logic tx_cand;

    assign lc_word = {loop_code_def_high, loop_code_def_low};
    assign lc_bit = lc_word[4'hF - lc_ptr_ff];
    assign d4_pos = (tx_in.frame_num >= D4_FRAMES) ? tx_in.frame_num - D4_FRAMES : tx_in.frame_num;
    assign d4_bit = D4_FPAT[4'hB - d4_pos[3:0]];
    assign esf_fps_slot = tx_in.frame_num[1:0] == 2'h3;
    assign esf_bit = esf_fps_slot ? ESF_FPS[3'h5 - tx_in.frame_num[4:2]] : tx_in.data;
    assign f_bit = ctrl.esf ? esf_bit : d4_bit;
    assign upper_nib = ssie_ff[0][UPPER_CAS_BIT] ? first_tx_signaling_reg[7:4] : CAS_UPPER_INT;
    assign lower_nib = ssie_ff[2][LOWER_CAS_BIT] ? first_tx_signaling_reg[3:0] : CAS_LOWER_INT;
    assign cas_word = {upper_nib, lower_nib};
    assign cas_bit = cas_word[3'h7 - tx_in.cas_idx];
    assign sig_take = gse & tx_chan_en & tx_in.sig_slot;
    assign tx_cand = ctrl.loop_code ? lc_bit :
        (~e1 & tx_in.fbit_slot) ? f_bit :
        (e1 & tx_in.cas_slot) ? cas_bit :
        sig_take ? tx_in.sig_bit : tx_in.data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lc_ptr_ff <= 4'h0;
        end else if (tx_in.valid) begin
            lc_ptr_ff <= lc_ptr_ff + 4'h1;
        end
    end

    // ****************************************************************
    // Density monitors (stream 0 transmit, stream 1 receive)
    // ****************************************************************
    logic [HIST_LEN-1:0] hist_ff [2];
    logic [7:0] cnt_ff [2][PD_WIN_MAX];
    logic [7:0] cnt_low [2][PD_WIN_MAX];
    logic [4:0] zrun_ff [2];
    logic [7:0] fill_ff [2];
    logic [PD_WIN_MAX-1:0] v0 [2];
    logic [PD_WIN_MAX-1:0] v1 [2];
    logic viol0 [2];
    logic viol [2];
    logic in_bit [2];
    logic in_valid [2];

    assign in_bit[0] = tx_cand | (ctrl.enforce & viol0[0]);
    assign in_bit[1] = rx_in.data;
    assign in_valid[0] = tx_in.valid;
    assign in_valid[1] = rx_in.valid;

    for (genvar s = 0; s < 2; s++) begin : g_mon
        for (genvar n = 0; n < PD_WIN_MAX; n++) begin : g_win
            logic filled;
            assign filled = fill_ff[s] >= 8'(WIN_UNIT * (n + 2));
            assign cnt_low[s][n] = cnt_ff[s][n] - {7'h00, hist_ff[s][WIN_UNIT * (n + 2) - 1]};
            assign v0[s][n] = filled & (cnt_low[s][n] < 8'(n + 1));
            assign v1[s][n] = filled & ((cnt_low[s][n] + 8'h01) < 8'(n + 1));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_ff[s][n] <= 8'h00;
                end else if (in_valid[s]) begin
                    cnt_ff[s][n] <= cnt_low[s][n] + {7'h00, in_bit[s]};
                end
            end
        end
        assign viol0[s] = (|v0[s]) | (zrun_ff[s] == MAX_ZERO_RUN);
        assign viol[s] = in_bit[s] ? |v1[s] : viol0[s];
        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                hist_ff[s] <= '0;
            end else if (in_valid[s]) begin
                hist_ff[s] <= {hist_ff[s][HIST_LEN-2:0], in_bit[s]};
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                zrun_ff[s] <= 5'h00;
            end else if (in_valid[s]) begin
                zrun_ff[s] <= in_bit[s] ? 5'h00 : (&zrun_ff[s] ? zrun_ff[s] : zrun_ff[s] + 5'h01);
            end
        end

        always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
                fill_ff[s] <= 8'h00;
            end else if (in_valid[s]) begin
                fill_ff[s] <= (fill_ff[s] == HIST_FULL) ? fill_ff[s] : fill_ff[s] + 8'h01;
            end
        end
    end

    // ****************************************************************
    // Status and interrupt
    // ****************************************************************
    assign clr_mask = (wr_en && mapped && sel_irqclr) ? wbyte : 8'h00;
    assign sts_set = (8'(in_valid[1] & viol[1]) << RX_DENS_BIT)
        | (8'(in_valid[0] & viol[0]) << TX_DENS_BIT);
    assign nxt_sts = (sts_ff & ~clr_mask) | sts_set;
    assign irq = |(sts_ff & irqen_ff);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sts_ff <= REG_RST;
        end else begin
            sts_ff <= nxt_sts;
        end
    end

    // ****************************************************************
    // Receive milliwatt replacement
    // ****************************************************************
    logic [2:0] dmw_idx_ff;
    logic [4:0] rx_chan_m1;
    logic rx_dmw_hit;
    logic dmw_bit;
    logic rx_bit;

    assign rx_chan_m1 = rx_in.chan - 5'h01;
    assign rx_dmw_hit = (rx_in.chan != 5'h00) & (rx_chan_m1 < 5'h08) & dmw1_ff[rx_chan_m1[2:0]];
    assign dmw_bit = DMW_CODE[6'h3F - {dmw_idx_ff, rx_in.bit_pos}];
    assign rx_bit = rx_dmw_hit ? dmw_bit : rx_in.data;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dmw_idx_ff <= 3'h0;
        end else if (rx_in.valid && rx_in.frame_start) begin
            dmw_idx_ff <= dmw_idx_ff + 3'h1;
        end
    end

    // ****************************************************************
    // Stream outputs
    // ****************************************************************
    logic tx_out_ff;
    logic tx_vld_ff;
    logic rx_out_ff;
    logic rx_vld_ff;

    assign tx_out = tx_out_ff;
    assign tx_out_valid = tx_vld_ff;
    assign rx_out = rx_out_ff;
    assign rx_out_valid = rx_vld_ff;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_out_ff <= 1'b0;
            tx_vld_ff <= 1'b0;
        end else begin
            tx_out_ff <= in_bit[0];
            tx_vld_ff <= tx_in.valid;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_out_ff <= 1'b0;
            rx_vld_ff <= 1'b0;
        end else begin
            rx_out_ff <= rx_bit;
            rx_vld_ff <= rx_in.valid;
        end
    end

endmodule

// ---- logic/tsc_pkg.sv ----
// Constants, register indices and stream carriers for the transmit signaling control block.
// Assumes an APB master with 32-bit data and byte registers in the low lane of each word.
package tsc_pkg;

    // ****************************************************************
    // Register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_TXCTL = 6'h05;
    localparam logic [5:0] IDX_COMCTL = 6'h07;
    localparam logic [5:0] IDX_INS_EN1 = 6'h08;
    localparam logic [5:0] IDX_INS_EN2 = 6'h09;
    localparam logic [5:0] IDX_INS_EN3 = 6'h0A;
    localparam logic [5:0] IDX_INS_EN4 = 6'h0B;
    localparam logic [5:0] IDX_DMW1 = 6'h0C;
    localparam logic [5:0] IDX_INFO = 6'h10;
    localparam logic [5:0] IDX_LINE = 6'h13;
    localparam logic [5:0] IDX_IRQEN = 6'h14;
    localparam logic [5:0] IDX_IRQCLR = 6'h15;

    // ****************************************************************
    // Field positions and reset values
    // ****************************************************************
    localparam int FMT_ESF_BIT = 2;
    localparam int ENFORCE_BIT = 1;
    localparam int LOOP_CODE_BIT = 0;
    localparam int GSE_BIT = 4;
    localparam int LINE_E1_BIT = 0;
    localparam int UPPER_CAS_BIT = 0;
    localparam int LOWER_CAS_BIT = 0;
    localparam int TX_DENS_BIT = 6;
    localparam int RX_DENS_BIT = 7;
    localparam logic [7:0] REG_RST = 8'h00;

    // ****************************************************************
    // Density limits and framing patterns
    // ****************************************************************
    localparam logic [4:0] MAX_ZERO_RUN = 5'h0F;
    localparam int PD_WIN_MAX = 23;
    localparam int WIN_UNIT = 8;
    localparam int HIST_LEN = 192;
    localparam logic [7:0] HIST_FULL = 8'hC0;
    localparam logic [11:0] D4_FPAT = 12'h8DC;
    localparam logic [5:0] ESF_FPS = 6'h0B;
    localparam logic [4:0] D4_FRAMES = 5'h0C;
    localparam logic [3:0] CAS_UPPER_INT = 4'h0;
    localparam logic [3:0] CAS_LOWER_INT = 4'hB;
    localparam logic [63:0] DMW_CODE = 64'h1E0B0B1E9E8B8B9E;

    // ****************************************************************
    // Stream carriers
    // ****************************************************************
    typedef struct packed {
        logic valid;
        logic data;
        logic [4:0] chan;
        logic fbit_slot;
        logic [4:0] frame_num;
        logic sig_slot;
        logic sig_bit;
        logic cas_slot;
        logic [2:0] cas_idx;
    } tsc_tx_slot_t;

    typedef struct packed {
        logic valid;
        logic data;
        logic [4:0] chan;
        logic [2:0] bit_pos;
        logic frame_start;
    } tsc_rx_slot_t;

    typedef struct packed {
        logic esf;
        logic enforce;
        logic loop_code;
    } tsc_ctrl_t;

endpackage

// ---- verif/tsc_ctrl_checker.sv ----
// Checker for the transmit signaling control block.
// Assumes a bind to the block's top module; it watches only those ports.
module tsc_ctrl_checker
    import tsc_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic irq,
    input wire tsc_tx_slot_t tx_in,
    input wire logic tx_out,
    input wire tsc_rx_slot_t rx_in,
    input wire logic rx_out,
    input wire logic frame_esf,
    input wire logic [29:0] b7_stuff_sel
);
    // ********
    // Shadow registers and assertions.
    // ********
    logic [7:0] ctl_ff, s1_ff, s2_ff, s3_ff, s4_ff, dm_ff;
    logic line_ff;
    logic [3:0] fm;
    logic fb_exp;
    wire wr = psel && penable && pwrite && pstrb[0];
    assign fm = 4'(tx_in.frame_num % 5'd12);
    assign fb_exp = D4_FPAT[4'd11 - fm];
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            {ctl_ff, s1_ff, s2_ff, s3_ff, s4_ff, dm_ff, line_ff} <= '0;
        end else if (wr) begin
            case (paddr)
                8'h1C: ctl_ff <= pwdata[7:0];
                8'h20: s1_ff <= pwdata[7:0];
                8'h24: s2_ff <= pwdata[7:0];
                8'h28: s3_ff <= pwdata[7:0];
                8'h2C: s4_ff <= pwdata[7:0];
                8'h30: dm_ff <= pwdata[7:0];
                8'h4C: line_ff <= pwdata[0];
                default: ;
            endcase
        end
    end
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_RST_CLEAR: assert property ($rose(presetn) |-> !frame_esf && !irq && b7_stuff_sel == '0)
        else $error("Controls not clear after reset.");
    AST_ESF_FOLLOWS: assert property (wr && paddr == 8'h1C |=> frame_esf == $past(pwdata[FMT_ESF_BIT]))
        else $error("Frame format output wrong.");
    AST_D4_FBIT: assert property (tx_in.valid && tx_in.fbit_slot && ctl_ff[2:0] == 3'h0 && !line_ff
        |=> tx_out == $past(fb_exp)) else $error("D4 framing bit wrong.");
    AST_T1_MAP: assert property (!line_ff |-> b7_stuff_sel[23:0] == {s3_ff, s2_ff, s1_ff})
        else $error("T1 channel map wrong.");
    AST_E1_MAP1: assert property (line_ff |-> b7_stuff_sel[6:0] == s1_ff[7:1])
        else $error("E1 channels 1 to 7 wrong.");
    AST_E1_MAP2: assert property (line_ff |-> b7_stuff_sel[14:7] == s2_ff)
        else $error("E1 channels 8 to 15 wrong.");
    AST_E1_MAP3: assert property (line_ff |-> b7_stuff_sel[21:15] == s3_ff[7:1])
        else $error("E1 channels 16 to 22 wrong.");
    AST_E1_MAP4: assert property (line_ff |-> b7_stuff_sel[29:22] == s4_ff)
        else $error("E1 channels 23 to 30 wrong.");
    AST_RX_PASS: assert property (rx_in.valid && dm_ff == 8'h00 |=> rx_out == $past(rx_in.data))
        else $error("Receive data altered.");
    CVR_ESF: cover property (frame_esf);
    CVR_IRQ: cover property ($rose(irq));
    CVR_CAS: cover property (line_ff && tx_in.valid && tx_in.cas_slot);
endmodule

bind tsc_t1e1_tx_sig_ctrl tsc_ctrl_checker tsc_ctrl_checker_inst (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .irq, .tx_in,
    .tx_out, .rx_in, .rx_out, .frame_esf, .b7_stuff_sel
);

// ---- verif/tsc_line_model.sv ----
// Far-end line receiver: keeps the last 16 sent bits and the current zero run.
// Assumes one line bit in each cycle where tx_out_valid is high.
module tsc_line_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic tx_out,
    input wire logic tx_out_valid,
    output logic [15:0] hist_ff,
    output logic [4:0] zrun_ff
);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hist_ff <= '0;
            zrun_ff <= '0;
        end else if (tx_out_valid) begin
            hist_ff <= {hist_ff[14:0], tx_out};
            zrun_ff <= tx_out ? 5'h00 : zrun_ff + {4'h0, zrun_ff != 5'h1F};
        end
    end
endmodule

// ---- verif/tsc_t1e1_tx_sig_ctrl_tb_top.sv ----
// Testbench for the transmit signaling control block.
// Assumes the package, the design, the line model and the checker are compiled first.
module tsc_t1e1_tx_sig_ctrl_tb_top
    import tsc_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [31:0] pwdata = '0;
    logic [7:0] lcl = 8'hC3, lch = 8'hA5, ts1 = 8'h5A;
    tsc_tx_slot_t tx_in = '0;
    tsc_rx_slot_t rx_in = '0;
    logic [31:0] prdata, q;
    logic pready, pslverr, irq, tx_out, tx_out_valid, rx_out, rx_out_valid, frame_esf, o, ok;
    logic [29:0] b7_stuff_sel;
    logic [15:0] hist;
    logic [4:0] zrun;
    logic [7:0] w;
    logic [31:0] lc2;
    logic [7:0] ra [8] = '{8'h14, 8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h40};
    logic [7:0] sa [4] = '{8'h20, 8'h24, 8'h28, 8'h2C};
    logic [7:0] sv [4] = '{8'hA5, 8'h3C, 8'h81, 8'h7E};
    int fails = 0, checks_done = 0;
    always #12.5 pclk = ~pclk;
    tsc_t1e1_tx_sig_ctrl tsc_t1e1_tx_sig_ctrl_inst (
        .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb(4'hF), .prdata,
        .pready, .pslverr, .irq, .tx_in, .loop_code_def_low(lcl), .loop_code_def_high(lch),
        .first_tx_signaling_reg(ts1), .tx_out, .tx_out_valid, .rx_in, .rx_out, .rx_out_valid,
        .frame_esf, .b7_stuff_sel
    );
    tsc_line_model tsc_line_model_inst (
        .pclk, .presetn, .tx_out, .tx_out_valid, .hist_ff(hist), .zrun_ff(zrun)
    );
    // ********
    // Access tasks.
    // ********
    task automatic stop_test();
        $display("Checks %0d, mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wn, input logic [7:0] a, input logic [7:0] d);
        int n;
        logic tmo;
        @(posedge pclk);
        {psel, penable, pwrite, paddr, pwdata} <= {2'b10, wn, a, 24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        o = pslverr;
        tmo = (pready !== 1'b1);
        {psel, penable} <= 2'b00;
        #1;
        if (tmo) begin
            fails++;
            stop_test();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(q, {24'h0, e});
    endtask
    function automatic tsc_tx_slot_t ts(input logic d, fb, sg, sb, cs,
        input logic [4:0] ch, fn, input logic [2:0] ci);
        return '{1'b1, d, ch, fb, fn, sg, sb, cs, ci};
    endfunction
    task automatic txb(input tsc_tx_slot_t s);
        @(posedge pclk);
        tx_in <= s;
        @(posedge pclk);
        tx_in <= '0;
        #1 o = tx_out;
    endtask
    task automatic rxb(input tsc_rx_slot_t s);
        @(posedge pclk);
        rx_in <= s;
        @(posedge pclk);
        rx_in <= '0;
        #1 o = rx_out;
        chk(rx_out_valid, 1'b1);
    endtask
    task automatic cas(input logic [7:0] e);
        for (int i = 0; i < 8; i++) begin
            txb(ts(0, 0, 0, 0, 1, 5'd0, 5'd0, 3'(i)));
            w[7 - i] = o;
        end
        chk(w, e);
    endtask
    // ********
    // Main sequence.
    // ********
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        foreach (ra[i]) rdc(ra[i], 8'h00);
        chk(frame_esf, 1'b0);
        apb(1'b0, 8'h3C, 8'h00);
        chk(o, 1'b1);
        for (int i = 0; i < 16; i++) begin
            if (i == 15) rdc(8'h40, 8'h00);
            txb(ts(0, 0, 0, 0, 0, 5'd1, 5'd0, 3'd0));
        end
        rdc(8'h40, 8'h40);
        chk(irq, 1'b0);
        wr(8'h50, 8'h40);
        chk(irq, 1'b1);
        wr(8'h54, 8'h40);
        rdc(8'h40, 8'h00);
        chk(irq, 1'b0);
        txb(ts(1, 0, 0, 0, 0, 5'd1, 5'd0, 3'd0));
        wr(8'h1C, 8'h02);
        for (int i = 0; i < 41; i++) begin
            txb(ts(0, 0, 0, 0, 0, 5'd1, 5'd0, 3'd0));
            chk(zrun <= 5'd15, 1'b1);
        end
        wr(8'h1C, 8'h01);
        repeat (16) txb(ts(0, 0, 0, 0, 0, 5'd1, 5'd0, 3'd0));
        @(posedge pclk);
        #1 ok = 1'b0;
        lc2 = {lch, lcl, lch, lcl};
        for (int r = 0; r < 16; r++) if (hist === lc2[31 - r -: 16]) ok = 1'b1;
        chk(ok, 1'b1);
        wr(8'h1C, 8'h00);
        for (int f = 0; f < 12; f++) begin
            txb(ts(0, 1, 0, 0, 0, 5'd1, 5'(f), 3'd0));
            chk(o, D4_FPAT[11 - f]);
        end
        wr(8'h1C, 8'h04);
        chk(frame_esf, 1'b1);
        for (int k = 0; k < 6; k++) begin
            txb(ts(0, 1, 0, 0, 0, 5'd1, 5'(4 * k + 3), 3'd0));
            chk(o, ESF_FPS[5 - k]);
        end
        wr(8'h1C, 8'h00);
        wr(8'h20, 8'h01);
        for (int g = 0; g < 2; g++) begin
            wr(8'h14, g ? 8'h10 : 8'h00);
            for (int c = 1; c < 3; c++) begin
                txb(ts(0, 0, 1, 1, 0, 5'(c), 5'd0, 3'd0));
                chk(o, g == 1 && c == 1);
            end
        end
        foreach (sa[i]) wr(sa[i], sv[i]);
        chk(b7_stuff_sel[23:0], {sv[2], sv[1], sv[0]});
        wr(8'h4C, 8'h01);
        foreach (sa[i]) rdc(sa[i], sv[i]);
        chk(b7_stuff_sel, {sv[3], sv[2][7:1], sv[1], sv[0][7:1]});
        cas(ts1);
        wr(8'h20, 8'hA4);
        wr(8'h28, 8'h80);
        cas({CAS_UPPER_INT, CAS_LOWER_INT});
        wr(8'h4C, 8'h00);
        rxb('{1'b1, 1'b1, 5'd2, 3'd0, 1'b0});
        wr(8'h30, 8'h01);
        rxb('{1'b1, 1'b1, 5'd2, 3'd0, 1'b0});
        chk(o, 1'b1);
        for (int b = 0; b < 8; b++) begin
            rxb('{1'b1, 1'b0, 5'd1, 3'(b), 1'b0});
            w[7 - b] = o;
        end
        ok = 1'b0;
        for (int k = 0; k < 8; k++) if (DMW_CODE[8 * k +: 8] === w) ok = 1'b1;
        chk(ok, 1'b1);
        wr(8'h54, 8'hFF);
        repeat (16) rxb('{1'b1, 1'b0, 5'd2, 3'd0, 1'b0});
        rdc(8'h40, 8'h80);
        stop_test();
    end
endmodule
